// file: hw/imas_map.svh
`ifndef IMAS_MAP_SVH
`define IMAS_MAP_SVH

// ==========================================================
// Register byte offsets
`define IMAS_OFF_CTRL2   8'h00
`define IMAS_OFF_BAUD    8'h04
`define IMAS_OFF_BUF     8'h08
`define IMAS_OFF_STAT    8'h0c
`define IMAS_OFF_CON3    8'h10

// ==========================================================
// Field positions, control_reg_two
`define IMAS_C2_START    0
`define IMAS_C2_RSTART   1
`define IMAS_C2_STOP     2
`define IMAS_C2_RCV      3
`define IMAS_C2_ACKLVL   4

// Field positions, status
`define IMAS_ST_WRITE_COLLISION_FLAG     0
`define IMAS_ST_BCOL     1
`define IMAS_ST_BUSY     2
`define IMAS_ST_ACK      3
`define IMAS_ST_RXAV     4

// Field position, serial_port_control_three
`define IMAS_C3_ACKT     7

// ==========================================================
// Reset values and counts
`define IMAS_RST_CTRL2   5'h00
`define IMAS_RST_BAUD    8'h00
`define IMAS_RST_CON3    7'h00
`define IMAS_BIT_LAST    4'h8

`endif

// file: hw/imas_pkg.sv
package imas_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    s_idle = 4'b0000,
    s_st1  = 4'b0001,
    s_st2  = 4'b0010,
    s_rs1  = 4'b0011,
    s_rs2  = 4'b0100,
    s_lo   = 4'b0101,
    s_hi   = 4'b0110,
    s_push = 4'b0111,
    s_sp1  = 4'b1000,
    s_sp2  = 4'b1001,
    s_sp3  = 4'b1010
  } imas_state_t;

  // ==========================================================
  // Module state records
  typedef struct packed {
    imas_state_t st;
    logic [4:0]  ctrl2;
    logic [7:0]  baud;
    logic [6:0]  con3;
    logic        write_collision_flag;
    logic        bcol;
    logic        ack_seen;
    logic        ackt;
    logic        rx_mode;
    logic        seen;
    logic        scl_oe;
    logic        sda_oe;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic        ad_sel;
    logic        ad_wr;
    logic [7:0]  ad_addr;
    logic [31:0] hrdata;
  } imas_top_t;

  typedef struct packed {
    logic [7:0] cnt;
  } imas_brg_t;

  typedef struct packed {
    logic [7:0] head;
    logic [7:0] tail;
    logic [1:0] cnt;
  } imas_buf_t;

endpackage

// file: hw/imas_strm_if.sv
`timescale 1ns/1ps

// ==========================================================
// Byte stream with valid and ready
interface imas_strm_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hw/imas_brg.sv
`timescale 1ns/1ps

// ==========================================================
// Baud rate generator: down counter with reload and hold
module imas_brg
  import imas_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       load,
  input  wire logic       hold,
  input  wire logic [7:0] reload,
  // Status
  output logic            zero
);

  imas_brg_t q;
  imas_brg_t n;

  // Next count: load wins, hold freezes, rollover reloads
  always_comb begin
    n = q;
    if (load) begin
      n.cnt = reload;
    end else if (!hold) begin
      if (q.cnt == 8'h00) begin
        n.cnt = reload;
      end else begin
        n.cnt = q.cnt - 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign zero = (q.cnt == 8'h00);

endmodule

// file: hw/imas_buf.sv
`timescale 1ns/1ps

// ==========================================================
// Two-entry buffer for received bytes
module imas_buf
  import imas_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Filling side
  imas_strm_if.snk  wr,
  // Draining side
  imas_strm_if.src  rd
);

  imas_buf_t q;
  imas_buf_t n;
  logic      push;
  logic      pop;

  // Handshakes
  assign wr.ready = (q.cnt != 2'd2);
  assign rd.valid = (q.cnt != 2'd0);
  assign rd.data  = q.head;
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Head always holds the oldest byte
  always_comb begin
    n = q;
    if (push && pop) begin
      if (q.cnt == 2'd1) begin
        n.head = wr.data;
      end else begin
        n.head = q.tail;
        n.tail = wr.data;
      end
    end else if (pop) begin
      n.head = q.tail;
      n.cnt  = q.cnt - 2'd1;
    end else if (push) begin
      if (q.cnt == 2'd0) begin
        n.head = wr.data;
      end else begin
        n.tail = wr.data;
      end
      n.cnt = q.cnt + 2'd1;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule

// file: hw/imas_top.sv
// Notes on behaviour
// - While SCL is released, the baud counter holds until SCL reads high.
// - Once SCL reads high, the baud counter reloads from the reload value and runs.
// - SCL high lasts at least one full baud rollover, even after stretching.
// - Buffer write while a sequence runs sets write collision and is dropped.
// - Low five command bits ignore writes while a start is in progress.
// - Stop drives SDA low, releases SCL, waits SCL high, counts, releases SDA, counts again, then samples SDA.
// - Stop: SDA still low after its release and the count flags collision.
// - Stop: SCL low after it reads high, before SDA floats, flags collision.
`timescale 1ns/1ps
`include "imas_map.svh"

module imas_top
  import imas_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Clock line, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // Data line, open drain
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  // ==========================================================
  // Declarations
  imas_top_t   q;
  imas_top_t   n;
  logic        brg_load;
  logic        brg_hold;
  logic        brg_zero;
  logic        push_v;
  logic        pop_r;
  logic        wr_buf;
  logic        coll;
  logic        rel;
  logic        tmo;
  imas_strm_if rx_in ();
  imas_strm_if rx_out ();

  // Line pull for a bit slot: receiver acks in slot nine, transmitter sends MSB
  function automatic logic bit_drive(input logic rx, input logic [3:0] cnt,
                                     input logic [7:0] sh, input logic ack);
    return (cnt == `IMAS_BIT_LAST) ? (rx && !ack) : (!rx && !sh[7]);
  endfunction

  // Start or restart under way
  function automatic logic start_busy(input imas_state_t s);
    return (s == s_st1) || (s == s_st2) || (s == s_rs1) || (s == s_rs2);
  endfunction

  // Read data for one register
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `IMAS_OFF_CTRL2: w[4:0] = q.ctrl2;
      `IMAS_OFF_BAUD:  w[7:0] = q.baud;
      `IMAS_OFF_BUF:   w[7:0] = rx_out.data;
      `IMAS_OFF_STAT: begin
        w[`IMAS_ST_WRITE_COLLISION_FLAG] = q.write_collision_flag;
        w[`IMAS_ST_BCOL] = q.bcol;
        w[`IMAS_ST_BUSY] = (q.st != s_idle);
        w[`IMAS_ST_ACK]  = q.ack_seen;
        w[`IMAS_ST_RXAV] = rx_out.valid;
      end
      `IMAS_OFF_CON3: begin
        w[6:0]           = q.con3;
        w[`IMAS_C3_ACKT] = q.ackt;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ==========================================================
  // Submodules
  imas_brg u_brg (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (brg_load),
    .hold    (brg_hold),
    .reload  (q.baud),
    .zero    (brg_zero)
  );

  imas_buf u_buf (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr      (rx_in),
    .rd      (rx_out)
  );

  // Buffer connections
  assign rx_in.valid  = push_v;
  assign rx_in.data   = q.shreg;
  assign rx_out.ready = pop_r;

  // ==========================================================
  // Next state
  always_comb begin
    n        = q;
    brg_load = 1'b0;
    brg_hold = 1'b0;
    push_v   = 1'b0;
    pop_r    = 1'b0;
    wr_buf   = 1'b0;
    coll     = 1'b0;

    // Address phase capture, read data registered for the data phase
    n.ad_sel  = hsel && hready && htrans[1];
    n.ad_wr   = hwrite;
    n.ad_addr = haddr[7:0];
    if (n.ad_sel && !hwrite) begin
      n.hrdata = rd_word(haddr[7:0]);
      pop_r    = (haddr[7:0] == `IMAS_OFF_BUF);
    end

    // Data phase writes; status clears come before hardware sets
    if (q.ad_sel && q.ad_wr) begin
      case (q.ad_addr)
        `IMAS_OFF_CTRL2: begin
          if (!start_busy(q.st)) begin
            n.ctrl2 = hwdata[4:0];
          end
        end
        `IMAS_OFF_BAUD: n.baud = hwdata[7:0];
        `IMAS_OFF_STAT: begin
          n.write_collision_flag = q.write_collision_flag && !hwdata[`IMAS_ST_WRITE_COLLISION_FLAG];
          n.bcol = q.bcol && !hwdata[`IMAS_ST_BCOL];
        end
        `IMAS_OFF_CON3: n.con3 = hwdata[6:0];
        `IMAS_OFF_BUF:  wr_buf = 1'b1;
        default: ;
      endcase
    end

    // Clock arbitration: count only once released SCL reads high
    rel = (q.st == s_hi) || (q.st == s_rs2) || (q.st == s_sp2);
    tmo = rel && q.seen && brg_zero;
    if (rel && !q.seen) begin
      brg_hold = 1'b1;
      if (scl_in) begin
        n.seen   = 1'b1;
        brg_load = 1'b1;
      end
    end

    // Sequencer
    case (q.st)
      s_idle: begin
        if (q.ctrl2[`IMAS_C2_START]) begin
          n.sda_oe = 1'b1;
          n.st     = s_st1;
          brg_load = 1'b1;
        end else if (q.ctrl2[`IMAS_C2_RSTART]) begin
          n.sda_oe = 1'b0;
          n.st     = s_rs1;
          brg_load = 1'b1;
        end else if (q.ctrl2[`IMAS_C2_STOP]) begin
          n.scl_oe = 1'b1;
          n.sda_oe = 1'b1;
          n.st     = s_sp1;
          brg_load = 1'b1;
        end else if (q.ctrl2[`IMAS_C2_RCV]) begin
          n.rx_mode = 1'b1;
          n.bitcnt  = 4'h0;
          n.scl_oe  = 1'b1;
          n.sda_oe  = bit_drive(1'b1, 4'h0, q.shreg, q.ctrl2[`IMAS_C2_ACKLVL]);
          n.st      = s_lo;
          brg_load  = 1'b1;
        end
      end
      s_st1: begin
        if (brg_zero) begin
          n.scl_oe = 1'b1;
          n.st     = s_st2;
          brg_load = 1'b1;
        end
      end
      s_st2: begin
        if (brg_zero) begin
          n.ctrl2[`IMAS_C2_START]  = 1'b0;
          n.ctrl2[`IMAS_C2_RSTART] = 1'b0;
          n.st                     = s_idle;
        end
      end
      s_rs1: begin
        if (brg_zero) begin
          n.scl_oe = 1'b0;
          n.seen   = 1'b0;
          n.st     = s_rs2;
          brg_load = 1'b1;
        end
      end
      s_rs2: begin
        if (tmo) begin
          n.sda_oe = 1'b1;
          n.st     = s_st1;
          brg_load = 1'b1;
        end
      end
      s_lo: begin
        if (brg_zero) begin
          n.scl_oe = 1'b0;
          n.seen   = 1'b0;
          n.st     = s_hi;
          brg_load = 1'b1;
        end
      end
      s_hi: begin
        if (tmo) begin
          n.scl_oe = 1'b1;
          if (q.bitcnt == `IMAS_BIT_LAST) begin
            n.ack_seen = sda_in;
            n.ackt     = 1'b0;
            n.sda_oe   = 1'b0;
            n.st       = q.rx_mode ? s_push : s_idle;
          end else begin
            n.shreg  = {q.shreg[6:0], sda_in};
            n.bitcnt = q.bitcnt + 4'h1;
            n.ackt   = (n.bitcnt == `IMAS_BIT_LAST);
            n.sda_oe = bit_drive(q.rx_mode, n.bitcnt, n.shreg,
                                 q.ctrl2[`IMAS_C2_ACKLVL]);
            n.st     = s_lo;
            brg_load = 1'b1;
          end
        end
      end
      s_push: begin
        // SCL stays low until the buffer takes the byte
        push_v = 1'b1;
        if (rx_in.ready) begin
          n.ctrl2[`IMAS_C2_RCV] = 1'b0;
          n.rx_mode             = 1'b0;
          n.st                  = s_idle;
        end
      end
      s_sp1: begin
        if (brg_zero && !sda_in) begin
          n.scl_oe = 1'b0;
          n.seen   = 1'b0;
          n.st     = s_sp2;
          brg_load = 1'b1;
        end
      end
      s_sp2: begin
        if (q.seen && !scl_in) begin
          coll = 1'b1;
        end else if (tmo) begin
          n.sda_oe = 1'b0;
          n.st     = s_sp3;
          brg_load = 1'b1;
        end
      end
      s_sp3: begin
        if (!scl_in) begin
          coll = 1'b1;
        end else if (brg_zero) begin
          if (!sda_in) begin
            coll = 1'b1;
          end else begin
            n.ctrl2[`IMAS_C2_STOP] = 1'b0;
            n.st                   = s_idle;
          end
        end
      end
      default: n.st = s_idle;
    endcase

    // Collision: free both lines and abandon the sequence
    if (coll) begin
      n.scl_oe     = 1'b0;
      n.sda_oe     = 1'b0;
      n.st         = s_idle;
      n.bcol       = 1'b1;
      n.ctrl2[3:0] = 4'h0;
      n.rx_mode    = 1'b0;
      n.ackt       = 1'b0;
    end

    // Buffer write: start a transmit or flag the collision
    if (wr_buf) begin
      if ((q.st != s_idle) || (|q.ctrl2[3:0])) begin
        n.write_collision_flag = 1'b1;
      end else begin
        n.shreg   = hwdata[7:0];
        n.rx_mode = 1'b0;
        n.bitcnt  = 4'h0;
        n.scl_oe  = 1'b1;
        n.sda_oe  = bit_drive(1'b0, 4'h0, hwdata[7:0], 1'b0);
        n.st      = s_lo;
        brg_load  = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.ctrl2 <= `IMAS_RST_CTRL2;
      q.baud  <= `IMAS_RST_BAUD;
      q.con3  <= `IMAS_RST_CON3;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata    = q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = q.scl_oe;
  assign sda_oe    = q.sda_oe;

endmodule

// file: verif/imas_chk.sv
`timescale 1ns/1ps
`include "imas_map.svh"

// ==========================================================
// Port-level checker of the serial master
module imas_chk
  import imas_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Serial lines
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  logic       rd_q;
  logic       wr_q;
  logic [7:0] ad_q;
  logic [7:0] baud;
  logic [8:0] hi_n;
  logic [8:0] lo_n;

  // Snoop reload value, count line high and pull cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
      baud <= 8'h00;
      hi_n <= 9'h000;
      lo_n <= 9'h000;
    end else begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      ad_q <= haddr[7:0];
      if (wr_q && ad_q == `IMAS_OFF_BAUD) baud <= hwdata[7:0];
      hi_n <= (scl_in && !scl_oe) ? hi_n + {8'h00, ~&hi_n} : 9'h000;
      lo_n <= scl_oe ? lo_n + {8'h00, ~&lo_n} : 9'h000;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_scl_hold: assert property (!scl_oe && !scl_in && !$past(scl_oe) |=> !scl_oe)
    else $error("clock pulled while stretched");
  a_high_time: assert property ($rose(scl_oe) |-> $past(hi_n) > {1'b0, baud})
    else $error("clock high too short");
  a_low_time: assert property ($fell(scl_oe) |-> lo_n > {1'b0, baud})
    else $error("clock low too short");
  a_stop_sda: assert property ($fell(sda_oe) && !scl_oe && scl_in |->
    $past(hi_n) > {1'b0, baud})
    else $error("data released early");
  a_start_setup: assert property ($rose(sda_oe) && !scl_oe |->
    $past(hi_n) > {1'b0, baud})
    else $error("data pulled early");
  a_rd_unmapped: assert property (rd_q && ad_q > `IMAS_OFF_CON3 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// file: verif/imas_peer.sv
`timescale 1ns/1ps

// ==========================================================
// Far side: stretching slave and a rival master
module imas_peer
(
  // Clock
  input wire logic       hclk,
  // Master pulls
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  // Behaviour
  input wire logic [7:0] stretch,
  input wire logic       grab_sda,
  input wire logic       grab_scl,
  // Own pulls
  output logic           scl_pull,
  output logic           sda_pull
);
  logic       grab_q = 1'b0;
  logic [7:0] hold_n = 8'h00;
  logic [1:0] hi_n = 2'h0;

  // Stretch armed while the master pulls, so no high glitch follows release
  always @(posedge hclk) begin
    if (scl_oe) hold_n <= stretch;
    else if (hold_n != 8'h00) hold_n <= hold_n - 8'h01;
    hi_n <= (!scl_oe && !scl_pull) ? hi_n + {1'b0, ~&hi_n} : 2'h0;
    if (!grab_scl) grab_q <= 1'b0;
    else if (hi_n == 2'h2) grab_q <= 1'b1;
  end

  assign scl_pull = (hold_n != 8'h00) || grab_q;
  assign sda_pull = grab_sda;
endmodule

// file: verif/tb_i2c_master_arbitration_stop.sv
`timescale 1ns/1ps
`include "imas_map.svh"

// ==========================================================
// Bench of the serial master
module tb_i2c_master_arbitration_stop;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dp_rd = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic scl_pull, sda_pull, grab_sda = 1'b0, grab_scl = 1'b0;
  logic [7:0] stretch = 8'h00, b;
  logic [31:0] exp_q[$];
  int n_fail = 0, check_count = 0, k;

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  // Wired-AND lines with pull-ups
  assign scl_in = !(scl_oe || scl_pull);
  assign sda_in = !(sda_oe || sda_pull);

  imas_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe));
  imas_peer peer_u (.hclk(hclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch),
    .grab_sda(grab_sda), .grab_scl(grab_scl), .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One single transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    dp_rd <= c;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    dp_rd <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, 1'b0, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0, 1'b1, r);
  endtask

  // Poll busy with a bound
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h4;
    @(posedge hclk);
    while (r[`IMAS_ST_BUSY] !== 1'b0 && n < 4000) begin
      xfer(1'b0, `IMAS_OFF_STAT, 32'h0, 1'b0, r);
      n++;
    end
    if (n == 4000) check("busy", 32'h1, 32'h0);
  endtask

  // Read data compared in its data phase
  always @(negedge hclk) begin
    if (dp_rd) check("hrdata", hrdata, exp_q.pop_front());
  end

  // Watchdog
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end

  initial begin
    void'($urandom(38579));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, storage and unmapped space
    rd(`IMAS_OFF_CTRL2, 32'h0);
    rd(`IMAS_OFF_BAUD, 32'h0);
    rd(`IMAS_OFF_STAT, 32'h0);
    rd(`IMAS_OFF_CON3, 32'h0);
    b = 8'($urandom_range(12, 4));
    v = $urandom;
    wr(`IMAS_OFF_BAUD, {24'hffffff, b});
    rd(`IMAS_OFF_BAUD, {24'h0, b});
    wr(`IMAS_OFF_CON3, v);
    rd(`IMAS_OFF_CON3, {25'h0, v[6:0]});
    wr(8'h14, v);
    rd(8'h14, 32'h0);
    // Transmit with a stretching slave, second write refused
    stretch <= 8'($urandom_range(30, 5));
    wr(`IMAS_OFF_BUF, {24'h0, v[15:8]});
    wr(`IMAS_OFF_BUF, {24'h0, ~v[15:8]});
    wait_idle();
    rd(`IMAS_OFF_STAT, 32'h9);
    wr(`IMAS_OFF_STAT, 32'h1);
    rd(`IMAS_OFF_STAT, 32'h8);
    // Command bits locked while a start runs
    wr(`IMAS_OFF_CTRL2, 32'h1);
    wr(`IMAS_OFF_CTRL2, 32'h4);
    rd(`IMAS_OFF_CTRL2, 32'h1);
    wait_idle();
    rd(`IMAS_OFF_CTRL2, 32'h0);
    check("scl_oe", {31'h0, scl_oe}, 32'h1);
    // Clean stop
    wr(`IMAS_OFF_CTRL2, 32'h4);
    wait_idle();
    rd(`IMAS_OFF_STAT, 32'h8);
    check("lines", {30'h0, scl_oe, sda_oe}, 32'h0);
    // Stop spoiled by a rival on data, then on clock
    for (k = 0; k < 2; k++) begin
      wr(`IMAS_OFF_CTRL2, 32'h1);
      wait_idle();
      grab_sda <= (k == 0);
      grab_scl <= (k == 1);
      wr(`IMAS_OFF_CTRL2, 32'h4);
      wait_idle();
      rd(`IMAS_OFF_STAT, 32'ha);
      rd(`IMAS_OFF_CTRL2, 32'h0);
      check("lines", {30'h0, scl_oe, sda_oe}, 32'h0);
      grab_sda <= 1'b0;
      grab_scl <= 1'b0;
      wr(`IMAS_OFF_STAT, 32'h2);
      rd(`IMAS_OFF_STAT, 32'h8);
    end
    // Bus rests high long enough before the receive pulls SCL
    repeat (16) @(posedge hclk);
    // Two received bytes fill the buffer, then drain it
    wr(`IMAS_OFF_CTRL2, 32'h8);
    wr(`IMAS_OFF_BUF, v);
    wait_idle();
    wr(`IMAS_OFF_CTRL2, 32'h8);
    wait_idle();
    // Own ACK in slot nine reads back as 0
    rd(`IMAS_OFF_STAT, 32'h11);
    rd(`IMAS_OFF_BUF, 32'hff);
    rd(`IMAS_OFF_BUF, 32'hff);
    // Empty buffer repeats its stale head; available flag drops
    rd(`IMAS_OFF_BUF, 32'hff);
    rd(`IMAS_OFF_STAT, 32'h1);
    print_verdict();
  end
endmodule

bind imas_top imas_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
